/* File: hw/fsp_host.sv */
// Notes on behaviour
// R1: protected sectors reject program and erase
// R2: unprotecting a sector re-enables program, erase
// R3: protect ops are bus writes under high voltage
// R4: protect all sectors before any unprotect
// R5: high-voltage reset allows writes to protected sectors
// R6: removing high voltage restores earlier protection
// R7: parts ship with all sectors unprotected
// R8: secured region 256 bytes, indicator on bit 7
// R9: customer-lockable part reports indicator zero
// R10: factory-locked part reports indicator one
// R11: overlay active refuses acceleration and bypass
// R12: after enter, first sector reads secured region
// R13: overlay lasts until exit or hardware reset
// R14: serial number sits at region start
// R15: locked secured region can never change
// R16: lock region: enter sequence then protect
// R17: exit overlay before touching the rest; the code refuses only reads and writes outside the first sector
// R18: protection of any sector is readable
// R19: verify read gives 01h protected, 00h not
// R20: outside first sector overlay changes nothing
`timescale 1ns/1ps
`default_nettype none
module fsp_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // flash pins
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_b,
    output logic fl_oe_b,
    output logic fl_we_b,
    output logic fl_reset_b,
    output logic fl_hv,
    input wire logic fl_ry_by_b
);
    import fsp_pkg::*;

    logic wr_q;
    logic [7:0] wa_q;
    logic [31:0] ctrl_q;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic ovl_q;
    logic ovl_d;
    fsp_op_t op_q;
    fsp_state_t st_q;
    fsp_state_t st_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [2:0] idx_q;
    logic [2:0] idx_d;
    logic [19:0] a_d;
    logic [15:0] dq_d;
    logic oe_en_d;
    logic ce_d;
    logic oe_d;
    logic we_d;
    logic rst_d;
    logic [15:0] dq_s;
    logic rdy_s;
    logic [37:0] cur;

    // flash inputs come from outside the clock domain
    fsp_sync #(.W(16)) u_dq_sync (
        .clk(clk), .rst_b(rst_b), .din(fl_dq_i), .dout(dq_s)
    );
    fsp_sync #(.W(1)) u_rdy_sync (
        .clk(clk), .rst_b(rst_b), .din(fl_ry_by_b), .dout(rdy_s)
    );

    // bus decode; zero wait states, never an error answer
    wire take = hsel && htrans[1] && hready;
    wire busy = st_q != S_IDLE;
    wire w_ctrl = wr_q && wa_q == OFF_CTRL;
    wire w_addr = wr_q && wa_q == OFF_ADDR;
    wire w_wdata = wr_q && wa_q == OFF_WDATA;
    wire w_cmd = wr_q && wa_q == OFF_CMD;
    wire w_stat = wr_q && wa_q == OFF_STAT;
    wire hsize_unused = ^hsize;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // status word shows the sequencer, overlay, ready and flags from the last read data
    wire prot_flag = rdata_q[7:0] == VERIFY_PROT; // see R19
    wire [31:0] stat_w = {26'h0, rdata_q[7], prot_flag, rdy_s, ovl_q,
        err_q, busy};
    wire [7:0] ra = haddr[7:0];
    wire [31:0] rd_word = (ra == OFF_CTRL) ? ctrl_q :
        (ra == OFF_ADDR) ? addr_q :
        (ra == OFF_WDATA) ? wdata_q :
        (ra == OFF_STAT) ? stat_w :
        (ra == OFF_RDATA) ? rdata_q : 32'h0000_0000;

    // command acceptance and refusal
    wire fsp_op_t op_new = fsp_op_t'(hwdata[2:0]);
    wire out_sect = addr_q[19:0] >= FIRST_SECT_LIM;
    wire arr_op = op_new == OP_READ || op_new == OP_WRITE;
    wire no_ack = op_new == OP_UNPROT && !ctrl_q[CTRL_ACK]; // see R4
    wire leave_1st = ovl_q && arr_op && out_sect; // see R17
    wire refuse = w_cmd && (busy || no_ack || leave_1st);
    wire go = w_cmd && !refuse;
    wire prot_op = op_q == OP_PROT || op_q == OP_UNPROT;
    wire step_end = st_q == S_HOLD && cnt_q == 8'h00;
    wire last = cur[37];

    // one step of a command: {last, read, address, data}
    function automatic logic [37:0] step_of(input fsp_op_t op,
        input logic [2:0] i, input logic [19:0] a, input logic [15:0] d);
        logic [37:0] s;
        s = {1'b1, 1'b0, a, d};
        case (op)
            OP_READ: s = {1'b1, 1'b1, a, d};
            OP_PROT, OP_UNPROT: s = {1'b1, 1'b0, a, D_PROT};
            OP_ENTER, OP_EXIT, OP_VERIFY: begin
                case (i)
                    3'h0: s = {1'b0, 1'b0, A_UNLK1, D_UNLK1};
                    3'h1: s = {1'b0, 1'b0, A_UNLK2, D_UNLK2};
                    3'h2: begin
                        if (op == OP_ENTER) begin
                            s = {1'b1, 1'b0, A_UNLK1, D_ENTER};
                        end else if (op == OP_EXIT) begin
                            s = {1'b0, 1'b0, A_UNLK1, D_EXIT};
                        end else begin
                            s = {1'b0, 1'b0, A_UNLK1, D_AUTOSEL};
                        end
                    end
                    3'h3: begin
                        if (op == OP_EXIT) begin
                            s = {1'b1, 1'b0, A_ZERO, D_EXIT2};
                        end else begin
                            s = {1'b0, 1'b1, a, d};
                        end
                    end
                    default: s = {1'b1, 1'b0, A_ZERO, D_RESET};
                endcase
            end
            default: s = {1'b1, 1'b0, a, d};
        endcase
        return s;
    endfunction

    assign cur = step_of(op_q, idx_q, addr_q[19:0], wdata_q[15:0]);

    // bus cycle sequencer; write strobe never meets output enable
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        a_d = fl_addr;
        dq_d = fl_dq_o;
        oe_en_d = fl_dq_oe;
        ce_d = fl_ce_b;
        oe_d = fl_oe_b;
        we_d = fl_we_b;
        rst_d = fl_reset_b;
        rdata_d = rdata_q;
        case (st_q)
            S_IDLE: begin
                if (go && op_new == OP_HWRST) begin
                    st_d = S_RSTP;
                    cnt_d = RST_CYC - 8'h01;
                    rst_d = 1'b0;
                end else if (go) begin
                    st_d = S_LOAD;
                    idx_d = 3'h0;
                end
            end
            S_LOAD: begin
                a_d = cur[35:16];
                dq_d = cur[15:0];
                oe_en_d = !cur[36];
                ce_d = 1'b0;
                cnt_d = SETUP_CYC - 8'h01;
                st_d = S_SETUP;
            end
            S_SETUP: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    we_d = cur[36]; // see R3
                    oe_d = !cur[36];
                    cnt_d = PULSE_CYC - 8'h01;
                    st_d = S_PULSE;
                end
            end
            S_PULSE: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    if (cur[36]) begin
                        rdata_d = {16'h0000, dq_s}; // see R18
                    end
                    we_d = 1'b1;
                    oe_d = 1'b1;
                    cnt_d = HOLD_CYC - 8'h01;
                    st_d = S_HOLD;
                end
            end
            S_HOLD: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    ce_d = 1'b1;
                    oe_en_d = 1'b0;
                    idx_d = idx_q + 3'h1;
                    st_d = last ? S_IDLE : S_LOAD;
                end
            end
            S_RSTP: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    rst_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    // overlay tracking follows the device: enter sets, exit or reset clears
    always_comb begin
        ovl_d = ovl_q;
        if (go && op_new == OP_HWRST) begin
            ovl_d = 1'b0; // see R13
        end else if (step_end && last && op_q == OP_ENTER) begin
            ovl_d = 1'b1; // see R12
        end else if (step_end && last && op_q == OP_EXIT) begin
            ovl_d = 1'b0; // see R17
        end
    end

    // ahb address phase capture and registered read data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_q <= take && hwrite;
            wa_q <= haddr[7:0];
            hrdata <= (take && !hwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // software registers; a refusal in the clearing cycle still sets
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            addr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            op_q <= OP_READ;
        end else begin
            if (w_ctrl) ctrl_q <= hwdata;
            if (w_addr) addr_q <= hwdata;
            if (w_wdata) wdata_q <= hwdata;
            if (go) op_q <= op_new;
            err_q <= refuse || (err_q && !(w_stat && hwdata[ST_ERR]));
        end
    end

    // sequencer and pin registers; all pins come straight from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            cnt_q <= 8'h00;
            idx_q <= 3'h0;
            ovl_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            fl_addr <= 20'h00000;
            fl_dq_o <= 16'h0000;
            fl_dq_oe <= 1'b0;
            fl_ce_b <= 1'b1;
            fl_oe_b <= 1'b1;
            fl_we_b <= 1'b1;
            fl_reset_b <= 1'b1;
            fl_hv <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            ovl_q <= ovl_d;
            rdata_q <= rdata_d;
            fl_addr <= a_d;
            fl_dq_o <= dq_d;
            fl_dq_oe <= oe_en_d;
            fl_ce_b <= ce_d;
            fl_oe_b <= oe_d;
            fl_we_b <= we_d;
            fl_reset_b <= rst_d;
            fl_hv <= ctrl_q[CTRL_HV] || (busy && prot_op); // see R3
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_we_fall;
        ##[1:12] $fell(fl_we_b);
    endsequence

    sequence s_we_low;
        (!fl_we_b)[*5] ##1 fl_we_b;
    endsequence

    a_prot_high_volt: assert property ( // see R3
        (prot_op && busy && !fl_we_b) |-> fl_hv)
        else $error("protect write without high voltage");

    a_unprot_guard: assert property ( // see R4
        (w_cmd && !busy && op_new == OP_UNPROT && !ctrl_q[CTRL_ACK])
        |=> (!busy && err_q))
        else $error("unprotect started without acknowledge");

    a_enter_three: assert property ( // see R16
        (go && op_new == OP_ENTER)
        |-> s_we_fall ##0 s_we_fall ##0 s_we_fall ##[1:12] ovl_q)
        else $error("enter sequence not three writes then overlay");

    a_leave_refused: assert property ( // see R17
        (w_cmd && ovl_q && arr_op && out_sect)
        |=> (st_q == S_IDLE && err_q && fl_ce_b))
        else $error("array access outside first sector in overlay");

    a_exit_clears: assert property ( // see R17
        (go && op_new == OP_EXIT) |-> ##[30:50] !ovl_q)
        else $error("exit sequence did not leave overlay");

    a_we_width: assert property ( // see R3
        $fell(fl_we_b) |-> s_we_low)
        else $error("write strobe not five cycles");

    a_strobe_excl: assert property ( // see R3
        fl_we_b || (fl_oe_b && fl_dq_oe && !fl_ce_b))
        else $error("bad strobe combination");

    a_reset_pulse: assert property ( // see R13
        $fell(fl_reset_b) |-> !ovl_q ##0 (!fl_reset_b)[*8])
        else $error("reset pulse too short or overlay kept");

    a_err_set_wins: assert property ( // see R4
        (refuse || (err_q && !(w_stat && hwdata[ST_ERR]))) |=> err_q)
        else $error("refusal or sticky error lost");
endmodule
`default_nettype wire

/* File: hw/fsp_pkg.sv */
package fsp_pkg;
    // clock and pin timing, each time in ns and its derived cycle count
    localparam int CLK_NS = 20;
    localparam int T_SETUP_NS = 40;
    localparam int T_PULSE_NS = 100;
    localparam int T_HOLD_NS = 40;
    localparam int T_RST_NS = 500;
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RST_CYC = 8'((T_RST_NS + CLK_NS - 1) / CLK_NS);

    // register byte offsets on the ahb-lite port
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_RDATA = 8'h14;

    // field positions
    localparam int CTRL_HV = 0;
    localparam int CTRL_ACK = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_ERR = 1;
    localparam int ST_OVL = 2;
    localparam int ST_RDY = 3;
    localparam int ST_PROT = 4;
    localparam int ST_IND = 5;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // flash command cycles
    localparam logic [19:0] A_UNLK1 = 20'h00555;
    localparam logic [19:0] A_UNLK2 = 20'h002AA;
    localparam logic [19:0] A_ZERO = 20'h00000;
    localparam logic [15:0] D_UNLK1 = 16'h00AA;
    localparam logic [15:0] D_UNLK2 = 16'h0055;
    localparam logic [15:0] D_ENTER = 16'h0088;
    localparam logic [15:0] D_EXIT = 16'h0090;
    localparam logic [15:0] D_EXIT2 = 16'h0000;
    localparam logic [15:0] D_AUTOSEL = 16'h0090;
    localparam logic [15:0] D_RESET = 16'h00F0;
    localparam logic [15:0] D_PROT = 16'h0060;
    localparam logic [7:0] VERIFY_PROT = 8'h01;
    localparam logic [19:0] FIRST_SECT_LIM = 20'h02000;

    typedef enum logic [2:0] {
        OP_READ = 3'h0, OP_WRITE = 3'h1, OP_ENTER = 3'h2, OP_EXIT = 3'h3,
        OP_VERIFY = 3'h4, OP_PROT = 3'h5, OP_UNPROT = 3'h6, OP_HWRST = 3'h7
    } fsp_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_LOAD = 3'h1, S_SETUP = 3'h3, S_PULSE = 3'h2,
        S_HOLD = 3'h6, S_RSTP = 3'h4
    } fsp_state_t;
endpackage

/* File: hw/fsp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // asynchronous level in, filtered level out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;

    // output follows only once the second and third stage agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
            dout <= '0;
        end else begin
            ff1_q <= din;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            if (ff2_q == ff3_q) begin
                dout <= ff3_q;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/flash_sector_protect_and_secure_region_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_sector_protect_and_secure_region_tb;
    import fsp_pkg::*;
    localparam logic [15:0] SN = 16'hC35A; // arbitrary serial seed
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hrdy, hresp, dq_oe, ce_b, oe_b, we_b, rs_b, hv, ryby;
    logic [19:0] fa, a;
    logic [15:0] dq_h, dq_m, dq_w, d, e;
    logic [6:0] s;
    int bad_count = 0, cmp_count = 0;

    always #10 clk = ~clk;
    assign dq_w = dq_oe ? dq_h : dq_m; // host wins while it drives

    fsp_host fsp_host_i (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata),
        .hresp(hresp), .fl_addr(fa), .fl_dq_o(dq_h), .fl_dq_oe(dq_oe),
        .fl_dq_i(dq_w), .fl_ce_b(ce_b), .fl_oe_b(oe_b), .fl_we_b(we_b),
        .fl_reset_b(rs_b), .fl_hv(hv), .fl_ry_by_b(ryby));
    fsp_flash_model #(.SN(SN)) fsp_flash_model_i (.fl_addr(fa),
        .dq_in(dq_w), .dq_out(dq_m), .fl_ce_b(ce_b), .fl_oe_b(oe_b),
        .fl_we_b(we_b), .fl_reset_b(rs_b), .fl_hv(hv), .fl_ry_by_b(ryby));

    function automatic logic [15:0] snw(input int i);
        return SN ^ 16'(i * 16'h1357);
    endfunction

    task automatic finish_test;
        if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one single ahb transfer; read data kept in r
    task automatic bus(input logic w, input logic [7:0] o,
            input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, o};
        do @(posedge clk); while (hrdy !== 1'b1 && n++ < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1 && n++ < 50);
        r = hrdata;
    endtask

    // issue a flash command and poll until it is done
    task automatic op(input fsp_op_t o, input logic [19:0] x,
            input logic [15:0] wd);
        int n;
        n = 0;
        bus(1'b1, OFF_ADDR, {12'h0, x});
        bus(1'b1, OFF_WDATA, {16'h0, wd});
        bus(1'b1, OFF_CMD, {29'h0, o});
        repeat (2) @(posedge clk);
        do bus(1'b0, OFF_STAT, 0); while (r[ST_BUSY] !== 1'b0 && n++ < 100);
        if (n > 100) begin
            bad_count++;
            $display("MISMATCH %0t command never finished", $time);
        end
    endtask

    task automatic pw(input logic [19:0] x, input logic [15:0] v);
        op(OP_WRITE, A_UNLK1, D_UNLK1);
        op(OP_WRITE, A_UNLK2, D_UNLK2);
        op(OP_WRITE, A_UNLK1, 16'h00A0);
        op(OP_WRITE, x, v);
    endtask

    task automatic rc(input logic [19:0] x, input logic [15:0] v);
        op(OP_READ, x, 16'h0000);
        bus(1'b0, OFF_RDATA, 0);
        chk(r[15:0], v);
    endtask

    task automatic sb(input int b, input logic v);
        bus(1'b0, OFF_STAT, 0);
        chk(r[b], v);
    endtask

    task automatic vfy(input logic [6:0] x, input logic p);
        op(OP_VERIFY, {x, 13'h0002}, 16'h0000);
        bus(1'b0, OFF_RDATA, 0);
        chk(r[7:0], p ? VERIFY_PROT : 8'h00);
        sb(ST_PROT, p);
    endtask

    // the run is a few thousand cycles; this is far beyond it
    initial begin
        #600_000;
        bad_count++;
        finish_test;
    end

    initial begin
        void'($urandom(32'h394B7BBA));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b0, OFF_CTRL, 0);
        chk(r, CTRL_RST);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 0);
        chk(r, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        sb(ST_RDY, 1'b1);
        for (int i = 0; i < 3; i++) vfy(7'($urandom), 1'b0);
        s = 7'($urandom_range(127, 1));
        a = {s, 13'($urandom)};
        d = 16'($urandom);
        e = d;
        pw(a, d);
        rc(a, e);
        // protect, then try to change it with and without high voltage
        bus(1'b1, OFF_CTRL, 32'h1);
        op(OP_PROT, {s, 13'h0000}, 16'h0000);
        bus(1'b1, OFF_CTRL, 32'h0);
        vfy(s, 1'b1);
        pw(a, 16'h0000);
        rc(a, e);
        bus(1'b1, OFF_CTRL, 32'h1);
        d = 16'($urandom);
        e = e & d;
        pw(a, d);
        bus(1'b1, OFF_CTRL, 32'h0);
        rc(a, e);
        pw(a, 16'h0000);
        rc(a, e);
        op(OP_UNPROT, {s, 13'h0040}, 16'h0000);
        sb(ST_ERR, 1'b1);
        bus(1'b1, OFF_STAT, 32'h2);
        sb(ST_ERR, 1'b0);
        // all sectors protected before the unprotect write
        bus(1'b1, OFF_CTRL, 32'h1);
        for (int i = 0; i < 128; i++)
            op(OP_PROT, {7'(i), 13'h0}, 16'h0);
        bus(1'b1, OFF_CTRL, 32'h3);
        op(OP_UNPROT, {s, 13'h0040}, 16'h0000);
        bus(1'b1, OFF_CTRL, 32'h0);
        vfy(s, 1'b0);
        d = 16'($urandom);
        e = e & d;
        pw(a, d);
        rc(a, e);
        // secured region
        op(OP_VERIFY, 20'h00041, 16'h0000);
        bus(1'b1, OFF_RDATA, 0);
        bus(1'b0, OFF_RDATA, 0);
        chk(r[7:0], 8'h03);
        sb(ST_IND, 1'b0);
        op(OP_ENTER, 20'h0, 16'h0);
        sb(ST_OVL, 1'b1);
        for (int i = 0; i < 8; i++) rc(20'(i), snw(i));
        d = 16'($urandom);
        pw(20'h00010, d);
        rc(20'h00010, d);
        op(OP_PROT, 20'h00000, 16'h0000);
        pw(20'h00010, 16'h0000);
        rc(20'h00010, d);
        vfy(7'h00, 1'b1);
        op(OP_READ, a, 16'h0000);
        sb(ST_ERR, 1'b1);
        bus(1'b1, OFF_STAT, 32'h2);
        op(OP_EXIT, 20'h0, 16'h0);
        sb(ST_OVL, 1'b0);
        rc(20'h00010, 16'hFFFF);
        rc(a, e);
        op(OP_ENTER, 20'h0, 16'h0);
        op(OP_HWRST, 20'h0, 16'h0);
        sb(ST_OVL, 1'b0);
        rc(20'h00010, 16'hFFFF);
        finish_test;
    end
endmodule
`default_nettype wire

/* File: sim/fsp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model #(
    parameter logic IND = 1'b0, // 0 customer lockable, 1 factory locked
    parameter logic [15:0] SN = 16'h5A3C, // arbitrary serial seed
    parameter int BUSY_NS = 300
) (
    // bus pins
    input wire logic [19:0] fl_addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    input wire logic fl_ce_b,
    input wire logic fl_oe_b,
    input wire logic fl_we_b,
    // control pins
    input wire logic fl_reset_b,
    input wire logic fl_hv,
    output logic fl_ry_by_b
);
    logic [15:0] mem [logic [19:0]];
    logic [15:0] sec [128]; // 128 words
    logic prot [128];
    logic lock, ovl, auto, pgm;
    logic [15:0] q, last;
    int step;
    wire logic first = fl_addr < 20'h02000;

    // shipping state
    initial begin
        for (int i = 0; i < 128; i++) begin
            sec[i] = (i < 8) ? SN ^ 16'(i * 16'h1357) : 16'hFFFF;
            prot[i] = 1'b0;
        end
        lock = IND;
        ovl = 1'b0;
        auto = 1'b0;
        pgm = 1'b0;
        step = 0;
        last = 16'h0000;
        fl_ry_by_b = 1'b1;
    end

    function automatic logic [15:0] arr(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    // program: bits only fall; ready pin low for a while
    task automatic store(input logic [19:0] a, input logic [15:0] d);
        fl_ry_by_b = 1'b0;
        fl_ry_by_b <= #(BUSY_NS) 1'b1;
        if (ovl && a < 20'h02000) begin
            if (!lock) sec[a[6:0]] = sec[a[6:0]] & d;
        end else if (!prot[a[19:13]] || fl_hv) begin
            mem[a] = arr(a) & d;
        end
    endtask

    // a hardware reset leaves the overlay
    always @(negedge fl_reset_b) begin
        ovl = 1'b0;
        auto = 1'b0;
        pgm = 1'b0;
        step = 0;
    end

    // command decode on the rising write strobe
    always @(posedge fl_we_b) begin
        if (!fl_ce_b && fl_reset_b) begin
            if (pgm) begin
                pgm = 1'b0;
                store(fl_addr, dq_in);
            end else if (dq_in[7:0] == 8'h60 && ovl && first) begin
                lock = 1'b1; // no high voltage needed
            end else if (dq_in[7:0] == 8'h60 && fl_hv) begin
                if (fl_addr[6]) prot = '{default: 1'b0};
                else prot[fl_addr[19:13]] = 1'b1;
            end else if (dq_in[7:0] == 8'hF0) begin
                auto = 1'b0;
                step = 0;
            end else if (ovl && auto && dq_in[7:0] == 8'h00) begin
                ovl = 1'b0;
                auto = 1'b0;
            end else if (step < 2 && dq_in[7:0] == (step ? 8'h55 : 8'hAA)
                    && fl_addr[10:0] == (step ? 11'h2AA : 11'h555)) begin
                step++;
            end else if (step == 2 && fl_addr[10:0] == 11'h555) begin
                step = 0;
                // bypass and acceleration are never decoded
                ovl = ovl | (dq_in[7:0] == 8'h88);
                auto = dq_in[7:0] == 8'h90;
                pgm = dq_in[7:0] == 8'hA0;
            end else begin
                step = 0;
            end
        end
    end

    // read data chosen when the output strobe falls
    always @(negedge fl_oe_b) begin
        if (auto && fl_addr[1:0] == 2'b10)
            q = {15'h0, (ovl && first) ? lock : prot[fl_addr[19:13]]};
        else if (auto)
            q = {8'h00, IND, 7'h03};
        else if (ovl && first)
            q = sec[fl_addr[6:0]];
        else
            q = arr(fl_addr);
    end

    // released bus shows the inverse so stale data never passes
    always @(posedge fl_oe_b) last = q;
    assign dq_out = (!fl_ce_b && !fl_oe_b) ? q : ~last;
endmodule
`default_nettype wire
